// File: shared/cfi_pkg.sv
// Constants, register map and types of the codec serial frame interface.
package cfi_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned DIV_W    = 12;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned POS_W    = 8;
  localparam int unsigned BADDR_W  = 2;

  // Register word addresses.
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [3:0] ADDR_DIVIDER  = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_RX_BASE  = 4'h4;
  localparam logic [3:0] ADDR_TX_BASE  = 4'h8;

  // Field positions in control_reg_one.
  localparam int unsigned C1_ENABLE_BIT   = 15;
  localparam int unsigned C1_IDLE_MODE    = 10;
  localparam int unsigned C1_FS_DIR       = 9;
  localparam int unsigned C1_FS_MODE_LSB  = 0;
  // Field positions in control_reg_two.
  localparam int unsigned C2_CLK_DIR      = 12;
  localparam int unsigned C2_FRAME_LSB    = 8;
  localparam int unsigned C2_WORD_LSB     = 0;
  // Field positions in the status register.
  localparam int unsigned ST_ADDR_LSB     = 0;
  localparam int unsigned ST_FRAME_LSB    = 4;
  localparam int unsigned ST_RUN_BIT      = 8;

  // Frame sync mode encodings.
  localparam logic [1:0] MODE_MULTI = 2'h0;
  localparam logic [1:0] MODE_I2S   = 2'h1;
  localparam logic [1:0] MODE_AC16  = 2'h2;
  localparam logic [1:0] MODE_AC20  = 2'h3;

  // Fixed link-frame figures.
  localparam logic [7:0] AC_LAST_POS   = 8'hFF;
  localparam logic [7:0] AC_SYNC_HIGH  = 8'h10;
  localparam logic [3:0] AC_WORD_LAST  = 4'hF;
  localparam logic [3:0] AC_FRAME_LAST = 4'hF;

  // Reset values.
  localparam logic [15:0] RST_CTRL_ONE = 16'h0000;
  localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
  localparam logic [11:0] RST_DIVIDER  = 12'h000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_RUN   = 3'b100
  } cfi_state_t;

endpackage

// File: rtl/cfi_core.sv
// Codec serial frame interface: bit clock, framing, shift register and buffers.
`timescale 1ns/1ns

module cfi_core (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic [cfi_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [cfi_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [cfi_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                      sck_i,
  output logic                           sck_o,
  output logic                           sck_oe_o,
  input  wire logic                      fs_i,
  output logic                           fs_o,
  output logic                           fs_oe_o,
  input  wire logic                      sdi_i,
  output logic                           sdo_o,
  output logic                           sdo_oe_o
);
  import cfi_pkg::*;

  typedef struct packed {
    logic                         en;
    logic                         en_q;
    logic                         idle_mode;
    logic                         fs_dir;
    logic [1:0]                   fs_mode;
    logic                         clk_dir;
    logic [CNT_W-1:0]             fl;
    logic [CNT_W-1:0]             ws;
    logic [DIV_W-1:0]             div;
    logic [7:0][WORD_W-1:0]       buffer;
    logic [DIV_W-1:0]             div_cnt;
    logic                         sck;
    logic                         sck_oe;
    logic                         sck_q;
    logic                         fs_q;
    cfi_state_t                   st;
    logic [BADDR_W-1:0]           baddr;
    logic [CNT_W-1:0]             bit_cnt;
    logic [CNT_W-1:0]             fcnt;
    logic [POS_W-1:0]             pos;
    logic [WORD_W-1:0]            sr;
    logic                         sdo;
    logic                         sdo_oe;
    logic                         fs;
    logic                         fs_oe;
    logic [DATA_W-1:0]            rdata;
  } cfi_core_state_t;

  cfi_core_state_t s_r;
  cfi_core_state_t s_nxt;

  logic              gen_on;
  logic              rise;
  logic              fall;
  logic              ac_mode;
  logic [CNT_W-1:0]  word_last;
  logic [CNT_W-1:0]  frame_last;
  logic [8:0]        frame_len;
  logic [POS_W-1:0]  len_last;
  logic [POS_W-1:0]  half_last;
  logic              end_of_word;
  logic              end_of_frame;
  logic              sync_seen;
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] tx_word;

  always_comb begin
    s_nxt = s_r;
    rise  = 1'b0;
    fall  = 1'b0;

    // mode select: codes 2 and 3 are the link modes.
    ac_mode = s_r.fs_mode[1];
    // word length: field plus one, ignored on the link.
    word_last  = ac_mode ? AC_WORD_LAST : s_r.ws;
    // fixed link frame: sixteen words of sixteen bits.
    frame_last = ac_mode ? AC_FRAME_LAST : s_r.fl;
    frame_len  = 9'((10'(word_last) + 10'h001) * (10'(frame_last) + 10'h001));
    len_last   = ac_mode ? AC_LAST_POS : 8'(frame_len - 9'h001);
    // An odd I2S frame length gives one more low period than high.
    half_last  = 8'((frame_len >> 1) - 9'h001);
    end_of_word  = (s_r.bit_cnt == word_last);
    end_of_frame = end_of_word && (s_r.fcnt == frame_last);

    // generator enable: zero divider disables it.
    // external clock: divider has no effect when clock is an input.
    gen_on = (s_r.div != 12'h000) && !s_r.clk_dir;

    // enable clear: the divider restarts once at the disable, then keeps running while the enable stays clear.
    if (!s_r.en && s_r.en_q) begin
      s_nxt.div_cnt = 12'h000;
      s_nxt.sck     = 1'b0;
    end else if (gen_on) begin
      // toggle every value plus one cycles.
      if (s_r.div_cnt == s_r.div) begin
        s_nxt.div_cnt = 12'h000;
        s_nxt.sck     = ~s_r.sck;
        rise          = ~s_r.sck;
        fall          = s_r.sck;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 12'h001;
      end
    end else begin
      s_nxt.div_cnt = 12'h000;
      s_nxt.sck     = 1'b0;
    end
    // input clock: edges come from the sampled pin.
    // Each external clock phase must last at least one cycle of clk_i to be seen.
    if (s_r.clk_dir) begin
      rise = sck_i && !s_r.sck_q;
      fall = !sck_i && s_r.sck_q;
    end
    s_nxt.sck_q = sck_i;
    s_nxt.en_q  = s_r.en;
    // bit clock pin: driven by the generator regardless of enable.
    s_nxt.sck_oe = gen_on;

    // pin ownership: frame sync driven only by an enabled master.
    // master when the direction bit is clear.
    s_nxt.fs_oe = s_r.en && !s_r.fs_dir;

    // Frame sync as seen by a slave, taken on the sampling edge.
    sync_seen = 1'b0;
    if (s_r.fs_mode == MODE_I2S) begin
      // either edge of frame sync starts a transfer.
      sync_seen = (fs_i != s_r.fs_q);
    end else begin
      // link tag slot follows a sampled high.
      sync_seen = fs_i;
    end

    // Short words are padded with zeros below, so software reads a signed fraction.
    rx_word = {s_r.sr[WORD_W-2:0], sdi_i} << (AC_WORD_LAST - word_last);
    tx_word = s_r.buffer[{1'b1, s_r.baddr}];

    if (!s_r.en) begin
      // module reset: counters, framing and address counter cleared.
      s_nxt.st      = ST_IDLE;
      s_nxt.baddr   = 2'h0;
      s_nxt.bit_cnt = 4'h0;
      s_nxt.fcnt    = 4'h0;
      s_nxt.pos     = 8'h00;
      s_nxt.sr      = 16'h0000;
      s_nxt.sdo     = 1'b0;
      s_nxt.sdo_oe  = 1'b0;
      s_nxt.fs      = 1'b0;
      s_nxt.fs_q    = 1'b0;
    end else begin
      if (fall) begin
        // The sync level is kept once per bit period, so an I2S edge is seen once.
        s_nxt.fs_q = fs_i;
        if (s_r.st == ST_RUN) begin
          // shift in at the LSB, oldest bit ends at the MSB.
          s_nxt.sr = {s_r.sr[WORD_W-2:0], sdi_i};
          if (end_of_word) begin
            // receive space uses prefix 0, left justified.
            s_nxt.buffer[{1'b0, s_r.baddr}] = rx_word;
            // one counter steps both spaces together.
            s_nxt.baddr = s_r.baddr + 2'h1;
          end
        end
        // syncs ignored until the last bit period of the frame.
        if (s_r.fs_dir && sync_seen &&
            (s_r.st != ST_RUN || end_of_frame)) begin
          s_nxt.st = ST_ARMED;
        end
      end
      if (rise) begin
        if ((s_r.st == ST_ARMED) || (!s_r.fs_dir && s_r.st == ST_IDLE)) begin
          s_nxt.st      = ST_RUN;
          s_nxt.bit_cnt = 4'h0;
          s_nxt.fcnt    = 4'h0;
          s_nxt.pos     = 8'h00;
        end else if (s_r.st == ST_RUN) begin
          if (end_of_word) begin
            // word counter wraps after the set length.
            s_nxt.bit_cnt = 4'h0;
            // frame counter steps when the word counter wraps.
            s_nxt.fcnt = end_of_frame ? 4'h0 : s_r.fcnt + 4'h1;
          end else begin
            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
          end
          s_nxt.pos = end_of_frame ? 8'h00 : s_r.pos + 8'h01;
          // slave goes quiet after one full frame.
          if (end_of_frame && s_r.fs_dir) begin
            s_nxt.st = ST_IDLE;
          end
        end
        if (s_nxt.st == ST_RUN) begin
          if (s_nxt.bit_cnt == 4'h0) begin
            // word fetched from the addressed shadow buffer.
            s_nxt.sr  = tx_word;
            s_nxt.sdo = tx_word[WORD_W-1];
          end else begin
            // next bit out is the MSB.
            s_nxt.sdo = s_r.sr[WORD_W-1];
          end
          s_nxt.sdo_oe = 1'b1;
        end else begin
          // idle periods drive zero or release the line.
          s_nxt.sdo    = 1'b0;
          s_nxt.sdo_oe = s_r.idle_mode;
        end
        // master sync is placed around the wrap to position zero.
        case (s_r.fs_mode)
          MODE_MULTI: begin
            // one bit period, just ahead of word zero.
            s_nxt.fs = (s_nxt.pos == len_last);
          end
          MODE_I2S: begin
            // half frame high, each edge one period ahead of a word.
            s_nxt.fs = (s_nxt.pos == len_last) || (s_nxt.pos < half_last);
          end
          MODE_AC16, MODE_AC20: begin
            // sixteen periods high, the rest low.
            s_nxt.fs = (s_nxt.pos == len_last) || (s_nxt.pos < (AC_SYNC_HIGH - 8'h01));
          end
          default: begin
            s_nxt.fs = 1'b0;
          end
        endcase
      end
      if (s_r.st != ST_RUN && !rise) begin
        s_nxt.sdo_oe = s_r.idle_mode;
      end
    end

    // Register port. Receive words are read only; unmapped reads give zero.
    // A store and a read of the same receive word in one cycle return the old word.
    s_nxt.rdata = 16'h0000;
    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL_ONE: begin
          s_nxt.en        = wdata_i[C1_ENABLE_BIT];
          s_nxt.idle_mode = wdata_i[C1_IDLE_MODE];
          s_nxt.fs_dir    = wdata_i[C1_FS_DIR];
          s_nxt.fs_mode   = wdata_i[C1_FS_MODE_LSB +: 2];
        end
        ADDR_CTRL_TWO: begin
          s_nxt.clk_dir = wdata_i[C2_CLK_DIR];
          s_nxt.fl      = wdata_i[C2_FRAME_LSB +: CNT_W];
          s_nxt.ws      = wdata_i[C2_WORD_LSB +: CNT_W];
        end
        ADDR_DIVIDER: begin
          s_nxt.div = wdata_i[DIV_W-1:0];
        end
        // transmit words sit behind prefix 1.
        ADDR_TX_BASE: begin
          s_nxt.buffer[3'h4] = wdata_i;
        end
        ADDR_TX_BASE + 4'h1: begin
          s_nxt.buffer[3'h5] = wdata_i;
        end
        ADDR_TX_BASE + 4'h2: begin
          s_nxt.buffer[3'h6] = wdata_i;
        end
        ADDR_TX_BASE + 4'h3: begin
          s_nxt.buffer[3'h7] = wdata_i;
        end
        default: begin
          // Status and receive words are read only; writes to them are dropped.
        end
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL_ONE: begin
          s_nxt.rdata[C1_ENABLE_BIT]        = s_r.en;
          s_nxt.rdata[C1_IDLE_MODE]         = s_r.idle_mode;
          s_nxt.rdata[C1_FS_DIR]            = s_r.fs_dir;
          s_nxt.rdata[C1_FS_MODE_LSB +: 2]  = s_r.fs_mode;
        end
        ADDR_CTRL_TWO: begin
          s_nxt.rdata[C2_CLK_DIR]              = s_r.clk_dir;
          s_nxt.rdata[C2_FRAME_LSB +: CNT_W]   = s_r.fl;
          s_nxt.rdata[C2_WORD_LSB +: CNT_W]    = s_r.ws;
        end
        ADDR_DIVIDER: begin
          s_nxt.rdata[DIV_W-1:0] = s_r.div;
        end
        ADDR_STATUS: begin
          s_nxt.rdata[ST_ADDR_LSB +: BADDR_W] = s_r.baddr;
          s_nxt.rdata[ST_FRAME_LSB +: CNT_W]  = s_r.fcnt;
          s_nxt.rdata[ST_RUN_BIT]             = (s_r.st == ST_RUN);
        end
        // receive words sit behind prefix 0, transmit words behind prefix 1.
        ADDR_RX_BASE: begin
          s_nxt.rdata = s_r.buffer[3'h0];
        end
        ADDR_RX_BASE + 4'h1: begin
          s_nxt.rdata = s_r.buffer[3'h1];
        end
        ADDR_RX_BASE + 4'h2: begin
          s_nxt.rdata = s_r.buffer[3'h2];
        end
        ADDR_RX_BASE + 4'h3: begin
          s_nxt.rdata = s_r.buffer[3'h3];
        end
        ADDR_TX_BASE: begin
          s_nxt.rdata = s_r.buffer[3'h4];
        end
        ADDR_TX_BASE + 4'h1: begin
          s_nxt.rdata = s_r.buffer[3'h5];
        end
        ADDR_TX_BASE + 4'h2: begin
          s_nxt.rdata = s_r.buffer[3'h6];
        end
        ADDR_TX_BASE + 4'h3: begin
          s_nxt.rdata = s_r.buffer[3'h7];
        end
        default: begin
          s_nxt.rdata = 16'h0000;
        end
      endcase
    end
  end

  // The whole state, buffers included, clears on reset so reads never return unknowns.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r           <= '0;
      s_r.en        <= RST_CTRL_ONE[C1_ENABLE_BIT];
      s_r.fs_mode   <= RST_CTRL_ONE[C1_FS_MODE_LSB +: 2];
      s_r.ws        <= RST_CTRL_TWO[C2_WORD_LSB +: CNT_W];
      s_r.div       <= RST_DIVIDER;
      s_r.st        <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every pin and the read port come straight from the state register.
  assign rdata_o  = s_r.rdata;
  assign sck_o    = s_r.sck;
  assign sck_oe_o = s_r.sck_oe;
  assign fs_o     = s_r.fs;
  assign fs_oe_o  = s_r.fs_oe;
  assign sdo_o    = s_r.sdo;
  assign sdo_oe_o = s_r.sdo_oe;

endmodule

// File: sim/cfi_assertions.sv
// Port-level checker for the codec serial frame interface.
`timescale 1ns/1ns
module cfi_assertions (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        sck_i,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        fs_i,
  input wire logic        fs_o,
  input wire logic        fs_oe_o,
  input wire logic        sdi_i,
  input wire logic        sdo_o,
  input wire logic        sdo_oe_o
);
  import cfi_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // A bit period opens where the internal clock rises.
  sequence s_int_rise;
    sck_oe_o && $rose(sck_o);
  endsequence
  sequence s_fs_move;
    fs_oe_o && $past(fs_oe_o) && sck_oe_o && $changed(fs_o);
  endsequence
  a_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside read slot");
  a_reset_quiet: assert property (disable iff (1'b0)
    !resetn_i |-> !sck_oe_o && !fs_oe_o && !sdo_oe_o)
    else $error("pin driven during reset");
  // A divider of one or more keeps each clock phase at least two cycles.
  a_sck_half_min: assert property (sck_oe_o && $past(sck_oe_o) && $changed(sck_o)
    |=> $stable(sck_o) || !sck_oe_o || $past(wr_i) || $past(wr_i, 2))
    else $error("bit clock phase too short");
  a_fs_on_rise: assert property (s_fs_move |-> s_int_rise)
    else $error("frame sync moved off a bit clock rise");
  a_sdo_on_rise: assert property (sdo_oe_o && $past(sdo_oe_o) && sck_oe_o && $changed(sdo_o)
    |-> s_int_rise)
    else $error("data out moved off a bit clock rise");
  a_fs_whole_period: assert property (s_fs_move |=> ($stable(fs_o) || !fs_oe_o)[*3])
    else $error("frame sync shorter than a bit period");
  a_fs_oe_cause: assert property ($changed(fs_oe_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("frame sync direction changed without a write");
  a_sck_oe_cause: assert property ($changed(sck_oe_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("bit clock direction changed without a write");
endmodule

// File: sim/cfi_codec_model.sv
// Codec model that clocks one slave frame with sync and data patterns.
`timescale 1ns/1ns
module cfi_codec_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [9:0] fs_pat_i,
  input  wire logic [9:0] sd_pat_i,
  output logic            sck_o,
  output logic            fs_o,
  output logic            sd_o
);
  initial begin
    sck_o = 1'h0;
    fs_o = 1'h0;
    sd_o = 1'h0;
  end
  // sync pulses sent
  // The clock stands still between frames, so nothing is clocked by accident.
  always @(posedge go_i) begin
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      sck_o <= 1'h1;
      fs_o <= fs_pat_i[9-i];
      sd_o <= sd_pat_i[9-i];
      repeat (2) @(posedge clk_i);
      sck_o <= 1'h0;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    sd_o <= ~sd_o;
  end
endmodule

// File: sim/testbench.sv
// Self-checking bench for the codec serial frame interface.
`timescale 1ns/1ns
module testbench;
  import cfi_pkg::*;
  logic        clk_i = 1'h0, resetn_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o, rv;
  logic        loop = 1'h1, sdo_q = 1'h0, m_go = 1'h0, m_sck, m_fs, m_sd;
  logic [9:0]  m_pat = 10'h18A;
  logic        sck_o, sck_oe_o, fs_o, fs_oe_o, sdo_o, sdo_oe_o;
  int          miscompares = 0, n_checks = 0, cyc = 0;
  wire         sck_w = sck_oe_o ? sck_o : m_sck;
  wire         fs_w = fs_oe_o ? fs_o : m_fs;
  wire         sdi_w = loop ? sdo_q : m_sd;
  cfi_core uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .fs_i(fs_w), .fs_o(fs_o), .fs_oe_o(fs_oe_o), .sdi_i(sdi_w),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));
  cfi_codec_model u_codec (.clk_i(clk_i), .go_i(m_go), .fs_pat_i(10'h280),
    .sd_pat_i(m_pat), .sck_o(m_sck), .fs_o(m_fs), .sd_o(m_sd));
  always #5 clk_i = ~clk_i;
  task automatic finish_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    sdo_q <= sdo_o;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1 rv = rdata_o;
  endtask
  task automatic wait_fs(logic v, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      #1 k++;
    end while (fs_o !== v && k < 2000);
  endtask
  task automatic measure(int hi, int per);
    int h, l;
    wait_fs(1'h0, h);
    wait_fs(1'h1, h);
    wait_fs(1'h0, h);
    wait_fs(1'h1, l);
    chk("fs high cycles", 16'(h), 16'(hi));
    chk("fs period cycles", 16'(h + l), 16'(per));
  endtask
  task automatic t_regs();
    wr(ADDR_STATUS, 16'hFFFF);
    rd(ADDR_STATUS);
    chk("status", rv, 16'h0000);
    wr(ADDR_RX_BASE, 16'hFFFF);
    rd(ADDR_RX_BASE);
    chk("rx word", rv, 16'h0000);
    rd(4'hC);
    chk("unmapped", rv, 16'h0000);
  endtask
  task automatic t_master();
    for (int k = 0; k < 4; k++) wr(4'(ADDR_TX_BASE + k), {4'(k + 9), 12'hABC});
    rd(4'hB);
    chk("tx word", rv, 16'hCABC);
    wr(ADDR_CTRL_TWO, 16'h0103);
    wr(ADDR_DIVIDER, 16'h0001);
    wr(ADDR_CTRL_ONE, 16'h8000);
    measure(4, 32);
    chk("fs oe", 16'(fs_oe_o), 16'h0001);
    chk("sdo oe", 16'(sdo_oe_o), 16'h0001);
    repeat (80) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      rd(4'(ADDR_RX_BASE + k));
      chk("rx loop", rv, {4'(k + 9), 12'h000});
    end
  endtask
  task automatic t_mode(logic [1:0] m, int hi, int per);
    wr(ADDR_CTRL_ONE, 16'h0000);
    wr(ADDR_CTRL_ONE, {14'h2000, m});
    measure(hi, per);
  endtask
  task automatic t_disable();
    wr(ADDR_CTRL_ONE, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1 chk("fs oe off", 16'(fs_oe_o), 16'h0000);
    chk("sdo oe off", 16'(sdo_oe_o), 16'h0000);
    chk("sck oe kept", 16'(sck_oe_o), 16'h0001);
    rd(ADDR_STATUS);
    chk("status", rv, 16'h0000);
    wr(ADDR_DIVIDER, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1 chk("sck oe off", 16'(sck_oe_o), 16'h0000);
    chk("sck off", 16'(sck_o), 16'h0000);
    wr(ADDR_CTRL_ONE, 16'h8600);
    repeat (2) @(posedge clk_i);
    #1 chk("sdo idle oe", 16'(sdo_oe_o), 16'h0001);
    chk("sdo idle", 16'(sdo_o), 16'h0000);
  endtask
  // The codec sends sync in periods 0 and 2; the second must be ignored.
  task automatic t_slave(logic [15:0] c1, logic [9:0] pat, logic [15:0] w0, logic [15:0] w1);
    loop <= 1'h0;
    m_pat <= pat;
    wr(ADDR_CTRL_ONE, 16'h0000);
    wr(ADDR_CTRL_TWO, 16'h1103);
    wr(ADDR_CTRL_ONE, c1);
    m_go <= 1'h1;
    repeat (50) @(posedge clk_i);
    m_go <= 1'h0;
    rd(ADDR_RX_BASE);
    chk("slave rx", rv, w0);
    rd(4'h5);
    chk("slave rx", rv, w1);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'h1;
    t_regs();
    t_master();
    t_mode(MODE_I2S, 16, 32);
    t_mode(MODE_AC16, 64, 1024);
    t_mode(MODE_AC20, 64, 1024);
    t_disable();
    t_slave(16'h8200, 10'h18A, 16'hC000, 16'h5000);
    t_slave(16'h8201, 10'h275, 16'h3000, 16'hA000);
    finish_test();
  end
endmodule
bind cfi_core cfi_assertions u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_i),
  .sck_o(sck_o), .sck_oe_o(sck_oe_o), .fs_i(fs_i), .fs_o(fs_o), .fs_oe_o(fs_oe_o),
  .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));
